// *** meot_consts.svh ***
/*
  Constants for the motion event output trigger: offsets, fields, resets.
  Assumes inclusion by bare name from the top module and the testbench.
*/
// Contract
// - Polarity 0 normally open, 1 closed; default 0
// - Polarity sets done output active level
// - New polarity acts only after store and reset
// - Nothing stored: power up loads default polarity
// - Event writes only in sequence or mode 0
// - Two event channels, both active together
// - Each channel targets output 1 to 4
// - Each channel holds target level 0 or 1
// - Time source fires after programmed milliseconds
// - Distance source fires when travel reaches threshold
// - Speed source fires when speed reaches setpoint
// - Writing zero deactivates the channel
// - Channel stays active until cleared
// - Clearing leaves target output unchanged
// - Each motion start restarts evaluation
// - Trigger drives target output to configured level
// - No event transitions on system-assigned output
`ifndef MEOT_CONSTS_SVH
`define MEOT_CONSTS_SVH
`define MEOT_ADDR_POL 4'h0
`define MEOT_ADDR_CMD 4'h1
`define MEOT_ADDR_MODE 4'h2
`define MEOT_ADDR_IO 4'h3
`define MEOT_ADDR_EV1 4'h4
`define MEOT_ADDR_EV2 4'h5
`define MEOT_ADDR_THR1 4'h6
`define MEOT_ADDR_THR2 4'h7
`define MEOT_ADDR_STAT 4'h8
`define MEOT_POL_DEFAULT 1'h0
`define MEOT_SRC_TIME 2'h1
`define MEOT_SRC_DIST 2'h2
`define MEOT_SRC_SPEED 2'h3
`define MEOT_SEL_NONE 3'h0
`define MEOT_SEL_MAX 3'h4
`define MEOT_TIME_MAX_MS 32'h0007a120
`define MEOT_SPEED_MIN 32'h00000001
`define MEOT_MS_PER_S 1000
`define MEOT_CLK_HZ 10000000
`define MEOT_LATCH_RESET 4'h0
`define MEOT_MODE_IMMEDIATE 8'h00
`endif

// *** meot_host.sv ***
/*
  Host model: Avalon-MM master issuing configuration writes and reads.
  Assumes a slave that answers by lowering waitrequest.
*/
`timescale 1ns/100ps
module meot_host (
  // Clock
  input wire logic clk_i,
  // Slave answer
  input wire logic wait_i,
  input wire logic [31:0] rdata_i,
  // Master request
  output logic [5:0] addr_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] wdata_o
);
  int timeouts = 0;
  initial begin
    addr_o = 6'h0;
    read_o = 1'b0;
    write_o = 1'b0;
    wdata_o = 32'h0;
  end
  // Held until waitrequest is seen low at a rising edge, or for at most 20 edges
  task automatic xfer(input logic rw, input logic [5:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    logic w;
    n = 0;
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    read_o <= ~rw;
    write_o <= rw;
    // Answer taken at the rising edge where waitrequest is low
    do begin
      @(posedge clk_i);
      n++;
      w = wait_i;
      q = rdata_i;
    end while (w && n < 20);
    if (w) timeouts++;
    read_o <= 1'b0;
    write_o <= 1'b0;
  endtask
endmodule

// *** meot_pkg.sv ***
/*
  Types for the motion event output trigger.
  Does not include the constants header and uses none of its macros.
*/
package meot_pkg;
  typedef struct packed {
    logic active;
    logic [1:0] src;
    logic level;
    logic [2:0] sel;
  } meot_ev_cfg_type;

  typedef enum logic [1:0] {
    MEOT_IDLE = 2'b01,
    MEOT_RUN = 2'b10
  } meot_motion_type;
endpackage

// *** meot_top.sv ***
/*
  Motion event output trigger: done output polarity with stored copy,
  two event channels driving four general outputs, Avalon-MM slave.
  Assumes motion inputs are synchronous to clk_i and update_i is a pulse.
*/
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "meot_consts.svh"
module meot_top
  import meot_pkg::*;
#(
  parameter int MS_CYCLES = `MEOT_CLK_HZ / `MEOT_MS_PER_S,
  parameter logic [31:0] POS_LIMIT = 32'h00ffffff,
  parameter logic [31:0] VEL_LIMIT = 32'h000fffff
) (
  // Clock and resets
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic pwr_up_i,
  // Avalon-MM slave
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Motion controller
  input wire logic seq_write_i,
  input wire logic motion_start_i,
  input wire logic motion_end_i,
  input wire logic update_i,
  input wire logic motion_done_i,
  input wire logic [31:0] travel_i,
  input wire logic [31:0] speed_i,
  // General outputs
  output logic [3:0] gen_out_o
);
  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;
  logic pol_pending, next_pol_pending;
  logic pol_active;
  logic pol_saved, next_pol_saved;
  logic saved_valid, next_saved_valid;
  logic [7:0] mode, next_mode;
  logic [3:0] latch, next_latch;
  logic [2:0] done_sel, next_done_sel;
  logic refused, next_refused;
  meot_ev_cfg_type cfg [2];
  meot_ev_cfg_type next_cfg [2];
  logic [31:0] thr [2];
  logic [31:0] next_thr [2];
  logic [1:0] fired, next_fired;
  meot_motion_type mstate, next_mstate;
  logic [31:0] ms_div, next_ms_div;
  logic [31:0] elapsed, next_elapsed;
  logic [3:0] out_q, next_out_q;
  logic wr_go, rd_go, ev_allowed;
  logic [3:0] widx;
  logic [1:0] fire;

  // Out-of-range settings are refused whole, never clipped
  function automatic logic cfg_ok(meot_ev_cfg_type c, logic [31:0] t);
    logic ok;
    ok = (c.sel != `MEOT_SEL_NONE) && (c.sel <= `MEOT_SEL_MAX);
    case (c.src)
      `MEOT_SRC_TIME: ok = ok && (t <= `MEOT_TIME_MAX_MS);
      `MEOT_SRC_DIST: ok = ok && (t <= POS_LIMIT);
      `MEOT_SRC_SPEED: ok = ok && (t >= `MEOT_SPEED_MIN) &&
                            (t <= VEL_LIMIT);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic cond_met(meot_ev_cfg_type c, logic [31:0] t,
                                    logic [31:0] el, logic [31:0] tr,
                                    logic [31:0] sp);
    logic m;
    case (c.src)
      `MEOT_SRC_TIME: m = (el >= t);
      `MEOT_SRC_DIST: m = (tr >= t);
      `MEOT_SRC_SPEED: m = (sp >= t);
      default: m = 1'b0;
    endcase
    return m;
  endfunction

  function automatic logic [1:0] pin_idx(logic [2:0] s);
    logic [2:0] d;
    d = s - 3'h1;
    return d[1:0];
  endfunction

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
  assign avs_readdata_o = rdata;
  assign gen_out_o = out_q;
  assign wr_go = avs_write_i & ack;
  assign rd_go = avs_read_i & ~ack;
  assign widx = avs_address_i[5:2];
  assign ev_allowed = seq_write_i || (mode == `MEOT_MODE_IMMEDIATE);

  always_comb begin
    next_ack = (avs_read_i | avs_write_i) & ~ack;
    next_rdata = rdata;
    if (rd_go) begin
      case (widx)
        `MEOT_ADDR_POL: next_rdata = {29'h0, saved_valid, pol_active,
                                      pol_pending};
        `MEOT_ADDR_MODE: next_rdata = {24'h0, mode};
        `MEOT_ADDR_IO: next_rdata = {23'h0, refused, 1'b0, done_sel,
                                     latch};
        `MEOT_ADDR_EV1: next_rdata = {25'h0, cfg[0]};
        `MEOT_ADDR_EV2: next_rdata = {25'h0, cfg[1]};
        `MEOT_ADDR_THR1: next_rdata = thr[0];
        `MEOT_ADDR_THR2: next_rdata = thr[1];
        `MEOT_ADDR_STAT: next_rdata = {24'h0, out_q, 1'b0,
                                       mstate == MEOT_RUN, fired};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_comb begin
    next_pol_pending = pol_pending;
    next_pol_saved = pol_saved;
    next_saved_valid = saved_valid;
    next_mode = mode;
    next_done_sel = done_sel;
    next_refused = refused;
    next_cfg = cfg;
    next_thr = thr;
    if (wr_go) begin
      case (widx)
        `MEOT_ADDR_POL: next_pol_pending = avs_writedata_i[0];
        `MEOT_ADDR_CMD: begin
          if (avs_writedata_i[0]) begin
            next_pol_saved = pol_pending;
            next_saved_valid = 1'b1;
          end
        end
        `MEOT_ADDR_MODE: next_mode = avs_writedata_i[7:0];
        `MEOT_ADDR_IO: begin
          next_done_sel = avs_writedata_i[6:4];
          next_refused = 1'b0;
        end
        `MEOT_ADDR_EV1, `MEOT_ADDR_EV2: begin
          if (!ev_allowed) begin
            next_refused = 1'b1;
          end else if (avs_writedata_i[6:0] == 7'h0) begin
            next_cfg[widx[0]] = '0;
          end else if (cfg_ok(avs_writedata_i[6:0], thr[widx[0]])) begin
            next_cfg[widx[0]] = avs_writedata_i[6:0];
            next_cfg[widx[0]].active = 1'b1;
          end else begin
            next_refused = 1'b1;
          end
        end
        `MEOT_ADDR_THR1, `MEOT_ADDR_THR2: begin
          if (ev_allowed) begin
            next_thr[widx[0]] = avs_writedata_i;
          end else begin
            next_refused = 1'b1;
          end
        end
        default: next_refused = refused;
      endcase
    end
    if (pwr_up_i) begin
      next_saved_valid = 1'b0;
      next_pol_saved = `MEOT_POL_DEFAULT;
    end
  end

  always_comb begin
    next_mstate = mstate;
    next_fired = fired;
    next_ms_div = ms_div;
    next_elapsed = elapsed;
    next_latch = latch;
    fire = 2'b00;
    if (wr_go && widx == `MEOT_ADDR_IO) begin
      next_latch = avs_writedata_i[3:0];
    end
    case (mstate)
      MEOT_IDLE: begin
        if (motion_start_i) begin
          next_mstate = MEOT_RUN;
        end
      end
      MEOT_RUN: begin
        if (motion_end_i) begin
          next_mstate = MEOT_IDLE;
        end
        if (ms_div == 32'(MS_CYCLES - 1)) begin
          next_ms_div = 32'h0;
          if (elapsed != 32'hffffffff) begin
            next_elapsed = elapsed + 32'h1;
          end
        end else begin
          next_ms_div = ms_div + 32'h1;
        end
        for (int i = 0; i < 2; i++) begin
          if (update_i && cfg[i].active && !fired[i] &&
              cond_met(cfg[i], thr[i], elapsed, travel_i, speed_i)) begin
            fire[i] = 1'b1;
            next_fired[i] = 1'b1;
            if (cfg[i].sel != done_sel) begin
              next_latch[pin_idx(cfg[i].sel)] = cfg[i].level;
            end
          end
        end
      end
      default: next_mstate = MEOT_IDLE;
    endcase
    if (motion_start_i) begin
      next_fired = 2'b00;
      next_ms_div = 32'h0;
      next_elapsed = 32'h0;
    end
  end

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (done_sel != `MEOT_SEL_NONE && pin_idx(done_sel) == 2'(k)) begin
        next_out_q[k] = motion_done_i ^ pol_active;
      end else begin
        next_out_q[k] = next_latch[k];
      end
    end
  end

  // Stored polarity survives srst_i; only pwr_up_i wipes it
  always_ff @(posedge clk_i) begin
    pol_saved <= next_pol_saved;
    saved_valid <= next_saved_valid;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack <= 1'b0;
      rdata <= 32'h0;
      pol_pending <= `MEOT_POL_DEFAULT;
      mode <= `MEOT_MODE_IMMEDIATE;
      done_sel <= `MEOT_SEL_NONE;
      refused <= 1'b0;
      cfg <= '{default: '0};
      thr <= '{default: 32'h0};
      fired <= 2'b00;
      mstate <= MEOT_IDLE;
      ms_div <= 32'h0;
      elapsed <= 32'h0;
      latch <= `MEOT_LATCH_RESET;
      out_q <= `MEOT_LATCH_RESET;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
      pol_pending <= next_pol_pending;
      mode <= next_mode;
      done_sel <= next_done_sel;
      refused <= next_refused;
      cfg <= next_cfg;
      thr <= next_thr;
      fired <= next_fired;
      mstate <= next_mstate;
      ms_div <= next_ms_div;
      elapsed <= next_elapsed;
      latch <= next_latch;
      out_q <= next_out_q;
    end
  end

  // Polarity load one edge after release, from storage or default
  logic rst_d;
  always_ff @(posedge clk_i) begin
    rst_d <= srst_i;
  end
  logic pol_load;
  assign pol_load = rst_d && !srst_i;
  logic pol_load_val;
  assign pol_load_val = saved_valid ? pol_saved : `MEOT_POL_DEFAULT;

  // Sole driver of the active polarity
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pol_active <= `MEOT_POL_DEFAULT;
    end else if (pol_load) begin
      pol_active <= pol_load_val;
    end
  end

  chk_pol_reload: assert property (@(posedge clk_i)
    $fell(srst_i) |=> pol_active == pol_load_val)
    else $error("polarity not reloaded after reset");
  chk_pol_stable: assert property (@(posedge clk_i) disable iff (srst_i)
    !pol_load |=> $stable(pol_active))
    else $error("polarity changed without reset");
  chk_done_level: assert property (@(posedge clk_i) disable iff (srst_i)
    done_sel == 3'h1 |=> out_q[0] == ($past(motion_done_i) ^ pol_active))
    else $error("done output level wrong");
  chk_ev_refused: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_go && widx == `MEOT_ADDR_EV1 && !ev_allowed |=> $stable(cfg[0]))
    else $error("event write taken outside mode 0");
  chk_clear_ev: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_go && widx == `MEOT_ADDR_EV2 && ev_allowed &&
    avs_writedata_i[6:0] == 7'h0 |=> !cfg[1].active)
    else $error("channel not cleared");
  chk_clear_keep: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_go && widx == `MEOT_ADDR_EV1 && fire == 2'b00 |=> $stable(latch))
    else $error("clear touched output");
  chk_fire_level: assert property (@(posedge clk_i) disable iff (srst_i)
    fire[0] && cfg[0].sel != done_sel && !fire[1] |=>
    latch[pin_idx($past(cfg[0].sel))] == $past(cfg[0].level))
    else $error("fired output not at level");
  chk_sys_block: assert property (@(posedge clk_i) disable iff (srst_i)
    fire[1] && cfg[1].sel == done_sel && !fire[0] && !wr_go
    |=> $stable(latch))
    else $error("system output moved by event");
  chk_fire_once: assert property (@(posedge clk_i) disable iff (srst_i)
    fire[0] && !motion_start_i |=> !fire[0])
    else $error("channel fired twice");
  chk_rearm: assert property (@(posedge clk_i) disable iff (srst_i)
    motion_start_i |=> fired == 2'b00 && elapsed == 32'h0)
    else $error("start did not rearm");
  chk_wait_one: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("waitrequest timing wrong");
  cov_fire_both: cover property (@(posedge clk_i) fire == 2'b11);
  cov_time_fire: cover property (@(posedge clk_i)
    fire[0] && cfg[0].src == `MEOT_SRC_TIME);
  cov_refused: cover property (@(posedge clk_i) $rose(refused));
  cov_store: cover property (@(posedge clk_i) $rose(saved_valid));
endmodule

// *** tb_meot_top.sv ***
/*
  Testbench for meot_top: bus through the host model, motion driven here.
  Assumes MS_CYCLES of 10, so one millisecond is ten clocks.
*/
`timescale 1ns/100ps
`include "meot_consts.svh"
module tb_meot_top;
  import meot_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic pwr_up_i = 1'b1;
  logic seq_write_i = 1'b0;
  logic motion_start_i = 1'b0;
  logic motion_end_i = 1'b0;
  logic update_i = 1'b0;
  logic motion_done_i = 1'b0;
  logic [31:0] travel_i = 32'h0;
  logic [31:0] speed_i = 32'h0;
  logic [5:0] adr;
  logic rd_s, wr_s, wreq;
  logic [31:0] wdat, rdat, q;
  logic [3:0] gen_out_o;
  int bad_count = 0;
  int n_checks = 0;
  always #50 clk_i = ~clk_i;
  meot_top #(.MS_CYCLES(10)) u_dut (.clk_i(clk_i), .srst_i(srst_i),
    .pwr_up_i(pwr_up_i), .avs_address_i(adr), .avs_read_i(rd_s),
    .avs_write_i(wr_s), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .seq_write_i(seq_write_i),
    .motion_start_i(motion_start_i), .motion_end_i(motion_end_i),
    .update_i(update_i), .motion_done_i(motion_done_i),
    .travel_i(travel_i), .speed_i(speed_i), .gen_out_o(gen_out_o));
  meot_host u_host (.clk_i(clk_i), .wait_i(wreq), .rdata_i(rdat),
    .addr_o(adr), .read_o(rd_s), .write_o(wr_s), .wdata_o(wdat));
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pins(input logic [3:0] exp);
    @(negedge clk_i);
    chk("gen_out", {28'h0, exp}, {28'h0, gen_out_o});
  endtask
  function automatic logic [31:0] ev(input logic [1:0] src,
    input logic lvl, input logic [2:0] sel);
    meot_ev_cfg_type c;
    c = '{1'b1, src, lvl, sel};
    return 32'(c);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a);
    u_host.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic start();
    @(posedge clk_i);
    motion_end_i <= 1'b1;
    @(posedge clk_i);
    motion_end_i <= 1'b0;
    motion_start_i <= 1'b1;
    @(posedge clk_i);
    motion_start_i <= 1'b0;
  endtask
  // Output moves one clock after the update edge
  task automatic upd(input logic [31:0] t, input logic [31:0] s);
    @(posedge clk_i);
    update_i <= 1'b1;
    travel_i <= t;
    speed_i <= s;
    @(posedge clk_i);
    update_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic t_pol();
    rd(6'h00);
    chk("pol", 32'h0, q);
    wr(6'h0c, 32'h20);
    motion_done_i <= 1'b1;
    cyc(2);
    pins(4'h2);
    wr(6'h00, 32'h1);
    cyc(2);
    pins(4'h2);
    wr(6'h04, 32'h1);
    srst_i <= 1'b1;
    cyc(1);
    srst_i <= 1'b0;
    cyc(2);
    rd(6'h00);
    chk("pol", 32'h6, q & 32'h6);
    wr(6'h0c, 32'h20);
    cyc(2);
    pins(4'h0);
    motion_done_i <= 1'b0;
    cyc(2);
    pins(4'h2);
    $display("t_pol finished");
  endtask
  task automatic t_mode();
    wr(6'h08, 32'h5);
    wr(6'h10, ev(`MEOT_SRC_DIST, 1'b1, 3'h1));
    rd(6'h10);
    chk("ev1", 32'h0, q);
    rd(6'h0c);
    chk("refused", 32'h100, q & 32'h100);
    seq_write_i <= 1'b1;
    wr(6'h18, 32'd100);
    wr(6'h10, ev(`MEOT_SRC_DIST, 1'b1, 3'h1));
    seq_write_i <= 1'b0;
    rd(6'h10);
    chk("ev1", ev(`MEOT_SRC_DIST, 1'b1, 3'h1), q & 32'h7f);
    wr(6'h08, 32'h0);
    wr(6'h1c, 32'd50);
    wr(6'h14, ev(`MEOT_SRC_SPEED, 1'b1, 3'h5));
    rd(6'h14);
    chk("ev2", 32'h0, q);
    wr(6'h14, ev(`MEOT_SRC_SPEED, 1'b1, 3'h4));
    $display("t_mode finished");
  endtask
  task automatic t_two();
    wr(6'h0c, 32'h20);
    start();
    upd(32'd99, 32'd49);
    pins(4'h2);
    upd(32'd100, 32'd49);
    pins(4'h3);
    upd(32'd100, 32'd50);
    pins(4'hb);
    rd(6'h20);
    chk("stat", 32'hb7, q);
    wr(6'h0c, 32'h20);
    upd(32'd200, 32'd60);
    pins(4'h2);
    start();
    upd(32'd100, 32'd50);
    pins(4'hb);
    $display("t_two finished");
  endtask
  task automatic t_clear();
    wr(6'h10, 32'h0);
    wr(6'h14, 32'h0);
    pins(4'hb);
    wr(6'h0c, 32'h20);
    start();
    upd(32'd300, 32'd90);
    pins(4'h2);
    $display("t_clear finished");
  endtask
  task automatic t_time();
    wr(6'h18, `MEOT_TIME_MAX_MS + 32'h1);
    wr(6'h10, ev(`MEOT_SRC_TIME, 1'b0, 3'h3));
    rd(6'h10);
    chk("ev1", 32'h0, q);
    wr(6'h18, 32'd3);
    wr(6'h10, ev(`MEOT_SRC_TIME, 1'b0, 3'h3));
    wr(6'h1c, 32'd0);
    // Deliberately aims at the done pin, which must ignore it
    wr(6'h14, ev(`MEOT_SRC_TIME, 1'b0, 3'h2));
    wr(6'h0c, 32'h24);
    start();
    cyc(15);
    upd(32'h0, 32'h0);
    pins(4'h6);
    cyc(20);
    upd(32'h0, 32'h0);
    pins(4'h2);
    $display("t_time finished");
  endtask
  task automatic wrap_up();
    bad_count += u_host.timeouts;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    cyc(10);
    srst_i <= 1'b0;
    pwr_up_i <= 1'b0;
    cyc(2);
    t_pol();
    t_mode();
    t_two();
    t_clear();
    t_time();
    wrap_up();
  end
  initial begin
    cyc(20000);
    bad_count++;
    $display("BAD watchdog expected finish seen hang");
    wrap_up();
  end
endmodule
